//--- design/mcr_map.vh
`ifndef MCR_MAP_VH
`define MCR_MAP_VH

// Number of integrator channels and channels per output driver.
`define MCR_CHANNELS      64
`define MCR_HALF          32

// Sequencer state codes, one-hot.
`define MCR_ST_IDLE       4'h1
`define MCR_ST_ARMED      4'h2
`define MCR_ST_READ       4'h4
`define MCR_ST_WAIT       4'h8

// Sequential mode: clocks per channel on one driver and lag of driver zero.
`define MCR_SEQ_STEP      8'h04
`define MCR_SEQ_SKEW      8'h02
// Sequential mode: driver one runs out at this count, driver zero two clocks later.
`define MCR_SEQ_END1      8'h80
`define MCR_SEQ_END0      8'h82
// Simultaneous mode: counts after the first load until both drivers are done.
`define MCR_PAR_END       8'h20

// Highest channel of each driver.
`define MCR_TOP_CH1       6'h3f
`define MCR_TOP_CH0       6'h1f

// Highest clock the controller may apply, in kHz, per mode.
`define MCR_SEQ_MAX_CLK_KHZ 15000
`define MCR_PAR_MAX_CLK_KHZ 3750

`endif

//--- design/mcr_driver.v
`timescale 1ns/100ps
`default_nettype none

// One differential output driver. It registers the channel value in the
// form chosen by the integrate direction, or the common-mode level or
// high impedance once the driver has nothing more to send.
module mcr_driver #(
    parameter W = 12
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         load,
    input  wire         idle,
    input  wire         hiz_after_read_enable,
    input  wire         integrate_direction_n,
    input  wire [W-1:0] sample,
    input  wire [W-1:0] upper_reference,
    input  wire [W-1:0] lower_reference,
    output reg  [W-1:0] out_pos,
    output reg  [W-1:0] out_neg,
    output reg          out_en
);

    // Wider sums keep the carry so the truncation below is deliberate.
    wire [W:0] up_neg   = {1'b0, lower_reference} + {1'b0, sample};
    wire [W:0] up_pos   = {1'b0, upper_reference} - {1'b0, sample};
    wire [W:0] dn_neg   = {1'b0, upper_reference} + {1'b0, sample};
    wire [W:0] dn_pos   = {1'b0, lower_reference} - {1'b0, sample};
    wire [W:0] cm_sum   = {1'b0, upper_reference} + {1'b0, lower_reference};

    // Output register: load wins over idle, otherwise the value is held.
    always @(posedge clk) begin
        if (reset) begin
            out_pos <= {W{1'b0}};
            out_neg <= {W{1'b0}};
            out_en  <= 1'b0;
        end else if (load) begin
            out_en <= 1'b1;
            if (integrate_direction_n) begin
                // Integrate-down: legs start from the opposite references.
                out_pos <= dn_pos[W-1:0];
                out_neg <= dn_neg[W-1:0];
            end else begin
                // Integrate-up.
                out_pos <= up_pos[W-1:0];
                out_neg <= up_neg[W-1:0];
            end
        end else if (idle) begin
            // Finished driver floats or rests at common mode.
            out_en  <= ~hiz_after_read_enable;
            out_pos <= cm_sum[W:1];
            out_neg <= cm_sum[W:1];
        end
    end

endmodule

`default_nettype wire

//--- design/mcr_readout.v
// What this block does
// - Channels 63-32 on driver one, 31-0 driver zero.
// - Parallel-select high drives both drivers together.
// - Read-start pulse starts read, clears channel counter.
// - Sequential: channel 63 at first edge after fall.
// - Sequential: each driver steps down every four clocks.
// - Sequential: driver zero lags driver one two clocks.
// - Hi-Z enable floats finished driver, else common-mode.
// - Sequential: new data every second clock edge.
// - Simultaneous: 31 and 63 first, one pair per clock.
// - Simultaneous: full read takes 33 clocks.
// - Direction pin picks up or down reference start.
// - End-of-conversion low while a read runs.
// - After read, wait for reset and start edges.
`timescale 1ns/100ps
`default_nettype none
`include "mcr_map.vh"

module mcr_readout #(
    parameter W = 12
) (
    input  wire                          clk,
    input  wire                          reset,
    input  wire                          read_start_in,
    input  wire                          integrator_reset_strobe,
    input  wire                          parallel_drive_pin,
    input  wire                          hiz_after_read_enable,
    input  wire                          integrate_direction_n,
    input  wire [`MCR_CHANNELS*W-1:0]    channel_values,
    input  wire [W-1:0]                  upper_reference,
    input  wire [W-1:0]                  lower_reference,
    output wire [W-1:0]                  out_pos1,
    output wire [W-1:0]                  out_neg1,
    output wire                          out_en1,
    output wire [W-1:0]                  out_pos0,
    output wire [W-1:0]                  out_neg0,
    output wire                          out_en0,
    output reg                           end_of_conversion
);

    // Sequencer state, one-hot.
    localparam [3:0] ST_IDLE  = `MCR_ST_IDLE;
    localparam [3:0] ST_ARMED = `MCR_ST_ARMED;
    localparam [3:0] ST_READ  = `MCR_ST_READ;
    localparam [3:0] ST_WAIT  = `MCR_ST_WAIT;

    reg  [3:0] state;            // Current sequencer state.
    reg  [3:0] next_state;       // State for the coming edge.
    reg  [7:0] chan_count;       // Clocks since the first channel was driven.
    reg  [7:0] next_chan_count;  // Counter value for the coming edge.
    reg        start_q;          // Read-start level of the last cycle.
    reg        integrator_reset_strobe_q;           // Integrator-reset level of the last cycle.
    reg        parallel;         // Mode caught at the start of a read.
    reg        next_parallel;    // Mode for the coming edge.
    reg        got_integrator_reset_strobe;         // An integrator-reset edge was seen while waiting.
    reg        next_got_integrator_reset_strobe;    // Flag value for the coming edge.

    // Load and idle strobes plus channel numbers for both drivers.
    reg        load1;
    reg        load0;
    reg        idle1;
    reg        idle0;
    reg  [5:0] chan1;
    reg  [5:0] chan0;

    // Edge detection on the controller strobes; the inputs are synchronous.
    wire       start_rise = read_start_in & ~start_q;
    wire       start_fall = ~read_start_in & start_q;
    wire       integrator_reset_strobe_rise  = integrator_reset_strobe & ~integrator_reset_strobe_q;

    // Count that the counter takes at this edge while reading.
    wire [7:0] count_inc  = chan_count + 8'h01;
    // Count shifted back by the skew of driver zero.
    wire [7:0] count_lag  = count_inc - `MCR_SEQ_SKEW;

    // Selects one channel's value from the flat input vector.
    function [W-1:0] pick;
        input [`MCR_CHANNELS*W-1:0] flat;
        input [5:0]                 idx;
        reg   [`MCR_CHANNELS*W-1:0] shifted;
        begin
            shifted = flat >> (idx * W);
            pick    = shifted[W-1:0];
        end
    endfunction

    // Strobe history for edge detection.
    always @(posedge clk) begin
        if (reset) begin
            start_q <= 1'b0;
            integrator_reset_strobe_q  <= 1'b0;
        end else begin
            start_q <= read_start_in;
            integrator_reset_strobe_q  <= integrator_reset_strobe;
        end
    end

    // Sequencer and driver steering. Both strobes may rise on one edge,
    // which lets a read overlap the integrator reset phase.
    always @* begin
        next_state      = state;
        next_chan_count = chan_count;
        next_parallel   = parallel;
        next_got_integrator_reset_strobe   = got_integrator_reset_strobe;
        load1           = 1'b0;
        load0           = 1'b0;
        idle1           = 1'b0;
        idle0           = 1'b0;
        chan1           = `MCR_TOP_CH1;
        chan0           = `MCR_TOP_CH0;
        case (state)
            ST_IDLE: begin
                // Nothing to send: counter holds, drivers stay idle.
                idle1 = 1'b1;
                idle0 = 1'b1;
                if (start_rise) begin
                    next_state      = ST_ARMED;
                    next_chan_count = 8'h00;
                end
            end
            ST_ARMED: begin
                idle1 = 1'b1;
                idle0 = 1'b1;
                if (start_fall) begin
                    // First channel goes out at the edge after the fall.
                    next_state      = ST_READ;
                    next_chan_count = 8'h00;
                    next_parallel   = parallel_drive_pin;
                    load1           = 1'b1;
                    idle1           = 1'b0;
                    if (parallel_drive_pin) begin
                        // Simultaneous: channels 31 and 63 together.
                        load0 = 1'b1;
                        idle0 = 1'b0;
                    end
                end
            end
            ST_READ: begin
                next_chan_count = count_inc;
                if (start_rise) begin
                    // A new start pulse aborts the read and rearms.
                    next_state      = ST_ARMED;
                    next_chan_count = 8'h00;
                    idle1           = 1'b1;
                    idle0           = 1'b1;
                end else if (parallel) begin
                    // One channel pair per clock, 33 clocks in all.
                    chan1 = `MCR_TOP_CH1 - count_inc[5:0];
                    chan0 = `MCR_TOP_CH0 - count_inc[5:0];
                    if (count_inc < `MCR_PAR_END) begin
                        load1 = 1'b1;
                        load0 = 1'b1;
                    end else begin
                        idle1      = 1'b1;
                        idle0      = 1'b1;
                        next_state = ST_WAIT;
                    end
                end else begin
                    // Driver one steps every four clocks from channel 63.
                    chan1 = `MCR_TOP_CH1 - count_inc[7:2];
                    // Driver zero steps two clocks later from channel 31.
                    chan0 = `MCR_TOP_CH0 - count_lag[7:2];
                    // The two drivers alternate, so fresh data every second edge.
                    if (count_inc < `MCR_SEQ_END1) begin
                        load1 = (count_inc[1:0] == 2'b00);
                    end else begin
                        idle1 = 1'b1;
                    end
                    if (count_inc < `MCR_SEQ_SKEW) begin
                        idle0 = 1'b1;
                    end else if (count_inc < `MCR_SEQ_END0) begin
                        load0 = (count_lag[1:0] == 2'b00);
                    end else begin
                        idle0      = 1'b1;
                        next_state = ST_WAIT;
                    end
                end
                if (next_state == ST_WAIT) begin
                    // A reset edge on the closing clock already counts: the set wins over the clear.
                    next_got_integrator_reset_strobe   = integrator_reset_strobe_rise;
                    next_chan_count = chan_count;
                end
            end
            ST_WAIT: begin
                // Hold until both an integrator reset and a start edge.
                idle1 = 1'b1;
                idle0 = 1'b1;
                if (start_rise && (got_integrator_reset_strobe || integrator_reset_strobe_rise)) begin
                    next_state      = ST_ARMED;
                    next_chan_count = 8'h00;
                    next_got_integrator_reset_strobe   = 1'b0;
                end else if (integrator_reset_strobe_rise) begin
                    next_got_integrator_reset_strobe = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                idle1      = 1'b1;
                idle0      = 1'b1;
            end
        endcase
    end

    // Sequencer registers. The end-of-conversion flag follows the state
    // that is being entered so that it changes on the same edge.
    always @(posedge clk) begin
        if (reset) begin
            state             <= ST_IDLE;
            chan_count        <= 8'h00;
            parallel          <= 1'b0;
            got_integrator_reset_strobe          <= 1'b0;
            end_of_conversion <= 1'b1;
        end else begin
            state             <= next_state;
            chan_count        <= next_chan_count;
            parallel          <= next_parallel;
            got_integrator_reset_strobe          <= next_got_integrator_reset_strobe;
            end_of_conversion <= ~(next_state == ST_ARMED || next_state == ST_READ);
        end
    end

    // Driver one carries the upper half of the channels.
    mcr_driver #(
        .W (W)
    ) u_drv1 (
        .clk                   (clk),
        .reset                 (reset),
        .load                  (load1),
        .idle                  (idle1),
        .hiz_after_read_enable (hiz_after_read_enable),
        .integrate_direction_n (integrate_direction_n),
        .sample                (pick(channel_values, chan1)),
        .upper_reference       (upper_reference),
        .lower_reference       (lower_reference),
        .out_pos               (out_pos1),
        .out_neg               (out_neg1),
        .out_en                (out_en1)
    );

    // Driver zero carries the lower half of the channels.
    mcr_driver #(
        .W (W)
    ) u_drv0 (
        .clk                   (clk),
        .reset                 (reset),
        .load                  (load0),
        .idle                  (idle0),
        .hiz_after_read_enable (hiz_after_read_enable),
        .integrate_direction_n (integrate_direction_n),
        .sample                (pick(channel_values, chan0)),
        .upper_reference       (upper_reference),
        .lower_reference       (lower_reference),
        .out_pos               (out_pos0),
        .out_neg               (out_neg0),
        .out_en                (out_en0)
    );

endmodule

`default_nettype wire

//--- bench/mcr_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

// Stand-in for the timing controller. It turns a bench request into the
// start and integrator reset strobes, moving them only on falling edges.
module mcr_ctl_model (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic with_integrator_reset_strobe,
    output var  logic read_start_in = 1'b0,
    output var  logic integrator_reset_strobe = 1'b0
);
    // Both strobes start low so no false rise is seen. The integrator reset
    // follows its own request, so it may rise with the start strobe or alone,
    // and both strobes may rise together to overlap readout and reset.
    always @(negedge clk) begin
        read_start_in <= go;
        integrator_reset_strobe <= with_integrator_reset_strobe;
    end
endmodule

`default_nettype wire

//--- bench/mcr_readout_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcr_map.vh"

// Watches the readout sequencer from its pins only.
module mcr_readout_chk #(
    parameter W = 12
) (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic                       read_start_in,
    input wire logic                       parallel_drive_pin,
    input wire logic                       hiz_after_read_enable,
    input wire logic                       integrate_direction_n,
    input wire logic [`MCR_CHANNELS*W-1:0] channel_values,
    input wire logic [W-1:0]               upper_reference,
    input wire logic [W-1:0]               lower_reference,
    input wire logic [W-1:0]               out_pos1,
    input wire logic [W-1:0]               out_neg1,
    input wire logic                       out_en1,
    input wire logic [W-1:0]               out_pos0,
    input wire logic [W-1:0]               out_neg0,
    input wire logic                       out_en0,
    input wire logic                       end_of_conversion
);
    // First code of each driver.
    wire [W-1:0] v63 = channel_values[63*W +: W];
    wire [W-1:0] v31 = channel_values[31*W +: W];
    // Reference each leg starts from, by integrate direction.
    wire [W-1:0] base_n = integrate_direction_n ? upper_reference : lower_reference;
    wire [W-1:0] base_p = integrate_direction_n ? lower_reference : upper_reference;
    // One extra bit keeps the carry of the common-mode sum.
    wire [W:0]   cm_sum = upper_reference + lower_reference;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_EOC_FALL: assert property ($fell(end_of_conversion) |-> $past(read_start_in))
        else $error("end of conversion fell without a start strobe");
    AST_FIRST1: assert property ($fell(read_start_in) && !end_of_conversion
        |=> out_en1 && out_neg1 == base_n + v63 && out_pos1 == base_p - v63)
        else $error("driver one did not open with its top channel");
    AST_PAR_FIRST0: assert property ($fell(read_start_in) && !end_of_conversion && parallel_drive_pin
        |=> out_neg0 == base_n + v31 && out_pos0 == base_p - v31)
        else $error("driver zero did not open with its top channel");
    AST_SEQ_LAG: assert property ($changed(out_pos1) && !end_of_conversion && !parallel_drive_pin
        |-> ##2 $changed(out_pos0))
        else $error("driver zero did not follow two clocks behind");
    AST_PAR_PAIR: assert property ($changed(out_pos1) && !end_of_conversion && parallel_drive_pin
        |-> $changed(out_pos0))
        else $error("drivers did not step together");
    AST_SEQ_LEN: assert property ($fell(read_start_in) && !end_of_conversion && !parallel_drive_pin
        |-> ##130 !end_of_conversion ##1 end_of_conversion)
        else $error("sequential read length wrong");
    AST_PAR_LEN: assert property ($fell(read_start_in) && !end_of_conversion && parallel_drive_pin
        |-> ##32 !end_of_conversion ##1 end_of_conversion)
        else $error("simultaneous read length wrong");
    AST_IDLE_EN: assert property (end_of_conversion && $stable(hiz_after_read_enable) && !$past(reset)
        |-> out_en0 == !hiz_after_read_enable && out_en1 == !hiz_after_read_enable)
        else $error("idle driver enable wrong");
    AST_IDLE_CM: assert property (end_of_conversion && !$past(reset)
        |-> out_pos1 == cm_sum[W:1] && out_neg0 == cm_sum[W:1])
        else $error("idle driver not at common mode");

    // Main scenarios reached.
    COV_SEQ: cover property ($fell(end_of_conversion) && !parallel_drive_pin);
    COV_PAR: cover property ($fell(end_of_conversion) && parallel_drive_pin);
    COV_REFUSED: cover property ($rose(read_start_in) && end_of_conversion ##1 end_of_conversion);
endmodule

`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcr_map.vh"

module tb;
    localparam int W = 12;
    localparam logic [W-1:0] UP = 12'hc00; // Upper reference code.
    localparam logic [W-1:0] LO = 12'h200; // Lower reference code.
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic with_integrator_reset_strobe = 1'b0;
    logic parallel_drive_pin = 1'b0;
    logic hiz_after_read_enable = 1'b0;
    logic integrate_direction_n = 1'b0;
    wire logic read_start_in;
    wire logic integrator_reset_strobe;
    wire logic [`MCR_CHANNELS*W-1:0] channel_values;
    wire logic [W-1:0] upper_reference = UP;
    wire logic [W-1:0] lower_reference = LO;
    wire logic [W-1:0] out_pos1, out_neg1, out_pos0, out_neg0;
    wire logic out_en1, out_en0, end_of_conversion;
    integer fails = 0;
    integer n_tests = 0;
    integer cyc = 0;

    // Distinct codes per channel so a wrong channel never matches.
    for (genvar k = 0; k < 64; k++) begin : g_ch
        assign channel_values[k*W +: W] = W'(k * 37 + 5);
    end

    always #25 clk = ~clk;

    mcr_readout #(.W(W)) dut (.clk, .reset, .read_start_in, .integrator_reset_strobe, .parallel_drive_pin,
        .hiz_after_read_enable, .integrate_direction_n, .channel_values, .upper_reference, .lower_reference,
        .out_pos1, .out_neg1, .out_en1, .out_pos0, .out_neg0, .out_en0, .end_of_conversion);
    mcr_ctl_model ctl (.clk, .go, .with_integrator_reset_strobe, .read_start_in, .integrator_reset_strobe);

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [2*W:0] exp, got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h got %h", what, exp, got);
        end
    endtask

    // Expected enable and legs; a negative channel means the idle level.
    function automatic logic [2*W:0] exp_drv(input logic d, h, input integer ch);
        logic [W-1:0] v;
        logic [W:0] s;
        s = {1'b0, UP} + {1'b0, LO};
        if (ch < 0) exp_drv = {!h, s[W:1], s[W:1]};
        else begin
            v = channel_values[ch*W +: W];
            exp_drv = d ? {1'b1, LO - v, UP + v} : {1'b1, UP - v, LO + v};
        end
    endfunction

    // One read: set mode pins, let idle settle, pulse start, check every edge.
    task automatic do_read(input logic p, h, d, i, run);
        integer t;
        integer c1;
        integer c0;
        @(negedge clk);
        parallel_drive_pin = p;
        hiz_after_read_enable = h;
        integrate_direction_n = d;
        repeat (3) @(posedge clk);
        go = 1'b1;
        with_integrator_reset_strobe = i;
        @(posedge clk);
        go = 1'b0;
        with_integrator_reset_strobe = 1'b0;
        #1;
        chk("eoc", {24'h0, !run}, {24'h0, end_of_conversion});
        @(posedge clk);
        for (t = 0; t < 136; t = t + 1) begin // Clock runs on past the 131 clocks a sequential read needs.
            #1;
            c1 = !run ? -1 : p ? (t < 32 ? 63 - t : -1) : (t < 128 ? 63 - t / 4 : -1);
            c0 = !run ? -1 : p ? (t < 32 ? 31 - t : -1) : (t > 1 && t < 130 ? 31 - (t - 2) / 4 : -1);
            chk("drv1", exp_drv(d, h, c1), {out_en1, out_pos1, out_neg1});
            chk("drv0", exp_drv(d, h, c0), {out_en0, out_pos0, out_neg0});
            chk("eoc", {24'h0, !run || t >= (p ? 32 : 130)}, {24'h0, end_of_conversion});
            @(posedge clk);
        end
    endtask

    // A hang is cut short here and counted.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        do_read(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        do_read(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        do_read(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        do_read(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        // An integrator reset alone while waiting releases a later start.
        with_integrator_reset_strobe = 1'b1;
        @(posedge clk);
        with_integrator_reset_strobe = 1'b0;
        do_read(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        do_read(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule

bind mcr_readout mcr_readout_chk #(.W(W)) chk (.clk, .reset, .read_start_in, .parallel_drive_pin,
    .hiz_after_read_enable, .integrate_direction_n, .channel_values, .upper_reference, .lower_reference,
    .out_pos1, .out_neg1, .out_en1, .out_pos0, .out_neg0, .out_en0, .end_of_conversion);

`default_nettype wire
